// file: fif_feature_reg.sv
// module: read-only fault injection capability register and the status recording it steers
`timescale 1ns/10ps

module fif_feature_reg
   import fif_pkg::*;
#(
   parameter int unsigned REC_INDEX  = 0,
   parameter bit          CAP_AV     = 1'b1,
   parameter bit          AV_FORCE   = 1'b0,
   parameter bit          AV0_UPDATE = 1'b1,
   parameter bit          CAP_PN     = 1'b1,
   parameter bit          CAP_ER     = 1'b1,
   parameter bit          CAP_CI     = 1'b1,
   parameter bit          CAP_OF     = 1'b1,
   parameter logic [1:0]  CAP_CE     = 2'h3,
   parameter bit          CAP_DE     = 1'b1,
   parameter bit          CAP_UEO    = 1'b1,
   parameter bit          CAP_UER    = 1'b1,
   parameter bit          CAP_UEU    = 1'b1,
   parameter bit          CAP_UC     = 1'b1,
   parameter bit          SUP_PN     = 1'b1,
   parameter bit          SUP_ER     = 1'b1,
   parameter bit          SUP_CI     = 1'b1,
   parameter bit          SUP_OF     = 1'b1,
   parameter bit          SUP_CE     = 1'b1,
   parameter bit          SUP_DE     = 1'b1,
   parameter bit          SUP_UEO    = 1'b1,
   parameter bit          SUP_UER    = 1'b1,
   parameter bit          SUP_UEU    = 1'b1,
   parameter bit          SUP_UC     = 1'b1,
   parameter bit          EXTENDED_FEATURE_FLAG        = 1'b1
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  mmSel,
   input  wire logic                  mmWe,
   input  wire logic [FIF_MM_AW-1:0]  mmAddr,
   input  wire logic [FIF_REG_W-1:0]  mmWdata,
   output logic      [FIF_REG_W-1:0]  mmRdata,
   output logic                       mmRvalid,
   input  wire logic                  sysRd,
   input  wire logic [FIF_SEL_W-1:0]  sysSel,
   output logic      [FIF_REG_W-1:0]  sysRdata,
   output logic                       sysRvalid,
   input  wire fif_inj_s              inj,
   input  wire fif_ctl_s              ctl,
   input  wire fif_clr_s              clr,
   input  wire logic                  addrWr,
   input  wire logic [FIF_ADDR_W-1:0] addrWdata,
   output fif_status_s                status,
   output logic      [FIF_ADDR_W-1:0] errAddr,
   output logic                       ctlAvReadsOne,
   output logic                       addrWritable,
   output logic      [5:0]            extSupport
);

   // effective capability bits, masked by node support
   localparam bit EFF_PN = CAP_PN & SUP_PN;
   localparam bit EFF_ER = CAP_ER & SUP_ER;
   localparam bit EFF_CI = CAP_CI & SUP_CI;
   localparam bit EFF_OF = CAP_OF & SUP_OF;
   localparam logic [1:0] EFF_CE =
      (SUP_CE && CAP_CE != FIF_GEN_RSVD) ? CAP_CE : FIF_GEN_NONE;
   localparam bit EFF_DE  = CAP_DE & SUP_DE;
   localparam bit EFF_UEO = CAP_UEO & SUP_UEO;
   localparam bit EFF_UER = CAP_UER & SUP_UER;
   localparam bit EFF_UEU = CAP_UEU & SUP_UEU;
   localparam bit EFF_UC  = CAP_UC & SUP_UC;

   localparam logic [FIF_MM_AW-1:0] MM_OFF =
      FIF_MM_BASE + FIF_MM_STRIDE * FIF_MM_AW'(REC_INDEX);
   localparam logic [FIF_SEL_W-1:0] SEL_ID = FIF_SEL_W'(REC_INDEX);

   typedef struct packed {
      logic [FIF_REG_W-1:0]  mmRdata;
      logic                  mmRvalid;
      logic [FIF_REG_W-1:0]  sysRdata;
      logic                  sysRvalid;
      fif_status_s           status;
      logic [FIF_ADDR_W-1:0] addr;
   } fif_state_s;

   logic [FIF_REG_W-1:0] capVal;
   fif_state_s           st_q;
   fif_state_s           st_d;
   logic                 mmHit;
   logic                 rec;
   logic                 ceOk;
   logic                 avSet;
   logic                 avNew;

   // bits above the address capability read as zero
   always_comb begin
      capVal           = FIF_REG_ZERO;
      capVal[FIF_B_AV] = CAP_AV;
      capVal[FIF_B_PN] = EFF_PN;
      capVal[FIF_B_ER] = EFF_ER;
      capVal[FIF_B_CI] = EFF_CI;
      capVal[FIF_B_CEH:FIF_B_CEL] = EFF_CE;
      capVal[FIF_B_DE]  = EFF_DE;
      capVal[FIF_B_UEO] = EFF_UEO;
      capVal[FIF_B_UER] = EFF_UER;
      capVal[FIF_B_UEU] = EFF_UEU;
      capVal[FIF_B_UC]  = EFF_UC;
      capVal[FIF_B_OF]  = EFF_OF;
   end

   assign mmHit = mmSel && (mmAddr == MM_OFF);
   assign rec   = inj.valid;

   // only codes that the generation field allows get recorded
   always_comb begin
      unique case (EFF_CE)
         FIF_GEN_NONSPEC: ceOk = (inj.ceCode == FIF_CE_NONSPEC);
         FIF_GEN_TRPER:   ceOk = (inj.ceCode == FIF_CE_TRANSIENT) ||
                                 (inj.ceCode == FIF_CE_PERSIST);
         default:         ceOk = 1'b0;
      endcase
   end

   // address flag on a record, per address capability
   always_comb begin
      if (CAP_AV) begin
         avSet = 1'b1;
         avNew = AV_FORCE ? 1'b1 : ctl.addrValid;
      end else begin
         avSet = AV0_UPDATE;
         avNew = 1'b1;
      end
   end

   always_comb begin
      st_d = st_q;
      // register reads; writes land nowhere
      st_d.mmRvalid  = mmSel && !mmWe;
      st_d.mmRdata   = (mmHit && !mmWe) ? capVal : FIF_REG_ZERO;
      st_d.sysRvalid = sysRd;
      st_d.sysRdata  = (sysRd && sysSel == SEL_ID) ? capVal : FIF_REG_ZERO;

      // software clears first; a record in the same cycle overrides them, except the address flag clear when avSet is low
      if (clr.addrValid) begin
         st_d.status.addrValid = 1'b0;
      end
      if (clr.overflowFlag) begin
         st_d.status.overflowFlag = 1'b0;
      end
      if (clr.valid) begin
         st_d.status.valid             = 1'b0;
         st_d.status.poisonFlag        = 1'b0;
         st_d.status.abortSignaledFlag = 1'b0;
         st_d.status.critFlag          = 1'b0;
         st_d.status.ce                = FIF_CE_NONE;
      end
      if (addrWr && !st_q.status.addrValid && !rec) begin
         st_d.addr = addrWdata;
      end

      if (rec) begin
         st_d.status.valid = 1'b1;
         if (avSet) begin
            st_d.status.addrValid = avNew;
         end
         if (!CAP_AV && AV0_UPDATE) begin
            st_d.addr = inj.accAddr;
         end
         st_d.status.poisonFlag = EFF_PN ? ctl.poisonFlag : inj.normPn;
         st_d.status.abortSignaledFlag =
            EFF_ER ? ctl.abortSignaledFlag : inj.normEr;
         st_d.status.critFlag = EFF_CI ? ctl.critFlag : inj.normCi;
         // normal overflow: set if a record was already held
         st_d.status.overflowFlag = EFF_OF ? ctl.overflowFlag :
            (st_q.status.valid | st_q.status.overflowFlag);
         st_d.status.ce = ceOk ? inj.ceCode : FIF_CE_NONE;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign mmRdata       = st_q.mmRdata;
   assign mmRvalid      = st_q.mmRvalid;
   assign sysRdata      = st_q.sysRdata;
   assign sysRvalid     = st_q.sysRvalid;
   assign status        = st_q.status;
   assign errAddr       = st_q.addr;
   assign ctlAvReadsOne = CAP_AV && AV_FORCE;
   assign addrWritable  = CAP_AV && !st_q.status.addrValid;
   assign extSupport    = EXTENDED_FEATURE_FLAG ? {SUP_CE, SUP_DE, SUP_UEO, SUP_UER, SUP_UEU, SUP_UC}
                              : 6'h00;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   property p_mm_read;
      mmSel && !mmWe && mmAddr == MM_OFF |=> mmRvalid && mmRdata == capVal;
   endproperty
   a_mm_read: assert property (p_mm_read)
      else $error("capability read by map returned wrong value");

   property p_mm_write;
      mmSel && mmWe ##1 mmSel && !mmWe && mmAddr == MM_OFF |=> mmRdata == capVal;
   endproperty
   a_mm_write: assert property (p_mm_write)
      else $error("write changed capability value");

   property p_sys_read;
      sysRd && sysSel == SEL_ID |=> sysRvalid && sysRdata == capVal;
   endproperty
   a_sys_read: assert property (p_sys_read)
      else $error("capability read by selector returned wrong value");

   property p_av0;
      rec && !CAP_AV && AV0_UPDATE |=> status.addrValid && errAddr == $past(inj.accAddr);
   endproperty
   a_av0: assert property (p_av0)
      else $error("address not captured on record");

   property p_av1;
      rec && CAP_AV |=> errAddr == $past(errAddr) &&
         status.addrValid == (AV_FORCE ? 1'b1 : $past(ctl.addrValid));
   endproperty
   a_av1: assert property (p_av1)
      else $error("address capability record handled wrongly");

   property p_addr_wr;
      addrWr && !status.addrValid && !rec |=> errAddr == $past(addrWdata);
   endproperty
   a_addr_wr: assert property (p_addr_wr)
      else $error("address write refused while flag clear");

   property p_pn;
      rec |=> status.poisonFlag == (EFF_PN ? $past(ctl.poisonFlag) : $past(inj.normPn));
   endproperty
   a_pn: assert property (p_pn)
      else $error("poison flag recorded wrongly");

   property p_er;
      rec |=> status.abortSignaledFlag ==
         (EFF_ER ? $past(ctl.abortSignaledFlag) : $past(inj.normEr));
   endproperty
   a_er: assert property (p_er)
      else $error("abort flag recorded wrongly");

   property p_ci;
      rec |=> status.critFlag == (EFF_CI ? $past(ctl.critFlag) : $past(inj.normCi));
   endproperty
   a_ci: assert property (p_ci)
      else $error("critical flag recorded wrongly");

   property p_of;
      rec |=> status.overflowFlag == (EFF_OF ? $past(ctl.overflowFlag) :
         ($past(status.valid) | $past(status.overflowFlag)));
   endproperty
   a_of: assert property (p_of)
      else $error("overflow flag recorded wrongly");

   property p_ce;
      rec |=> status.valid && status.ce ==
         ((EFF_CE == FIF_GEN_NONSPEC && $past(inj.ceCode) == FIF_CE_NONSPEC) ||
          (EFF_CE == FIF_GEN_TRPER && $past(inj.ceCode) != FIF_CE_NONSPEC &&
           $past(inj.ceCode) != FIF_CE_NONE) ? $past(inj.ceCode) : FIF_CE_NONE);
   endproperty
   a_ce: assert property (p_ce)
      else $error("corrected code recorded against generation field");

   property p_mm_wr_quiet;
      mmSel && mmWe |=> !mmRvalid && mmRdata == FIF_REG_ZERO;
   endproperty
   a_mm_wr_quiet: assert property (p_mm_wr_quiet)
      else $error("write to map produced read data");

   property p_mm_miss;
      mmSel && !mmWe && mmAddr != MM_OFF |=> mmRvalid && mmRdata == FIF_REG_ZERO;
   endproperty
   a_mm_miss: assert property (p_mm_miss)
      else $error("unmapped read returned nonzero data");

   property p_sys_miss;
      sysRd && sysSel != SEL_ID |=> sysRvalid && sysRdata == FIF_REG_ZERO;
   endproperty
   a_sys_miss: assert property (p_sys_miss)
      else $error("other record selector returned nonzero data");

   property p_mm_idle;
      !mmSel |=> !mmRvalid && mmRdata == FIF_REG_ZERO;
   endproperty
   a_mm_idle: assert property (p_mm_idle)
      else $error("map read data without a read");

   property p_sys_idle;
      !sysRd |=> !sysRvalid && sysRdata == FIF_REG_ZERO;
   endproperty
   a_sys_idle: assert property (p_sys_idle)
      else $error("selector read data without a read");

   property p_addr_keep;
      addrWr && status.addrValid && !rec |=> errAddr == $past(errAddr);
   endproperty
   a_addr_keep: assert property (p_addr_keep)
      else $error("address written while flag set");

   property p_av_hold;
      !rec && !clr.addrValid |=> status.addrValid == $past(status.addrValid);
   endproperty
   a_av_hold: assert property (p_av_hold)
      else $error("address flag changed without record or clear");

   property p_av0_keep;
      rec && !CAP_AV && !AV0_UPDATE && !clr.addrValid |=>
         errAddr == $past(errAddr) && status.addrValid == $past(status.addrValid);
   endproperty
   a_av0_keep: assert property (p_av0_keep)
      else $error("address syndrome changed in keep mode");

   c_record: cover property (rec ##1 status.valid);
   c_sw_addr: cover property (addrWr && !status.addrValid ##1 rec);
   c_of_set: cover property (rec ##1 rec ##1 status.overflowFlag);
   c_mm_read: cover property (mmHit && !mmWe ##1 mmRvalid);
   c_ce_code: cover property (rec && inj.ceCode == FIF_CE_NONSPEC ##1 status.ce == FIF_CE_NONSPEC);

endmodule // fif_feature_reg

// file: fif_pkg.sv
// package: field layout, access constants and carriers of the fault injection feature register
package fif_pkg;

   localparam int unsigned FIF_REG_W      = 64;
   localparam int unsigned FIF_ADDR_W     = 64;
   localparam int unsigned FIF_MM_AW      = 16;
   localparam int unsigned FIF_SEL_W      = 16;

   // memory-mapped placement: base plus one stride per record
   localparam logic [FIF_MM_AW-1:0] FIF_MM_BASE   = 16'h0800;
   localparam logic [FIF_MM_AW-1:0] FIF_MM_STRIDE = 16'h0040;

   // capability bit positions
   localparam int unsigned FIF_B_OF  = 0;
   localparam int unsigned FIF_B_UC  = 1;
   localparam int unsigned FIF_B_UEU = 2;
   localparam int unsigned FIF_B_UER = 3;
   localparam int unsigned FIF_B_UEO = 4;
   localparam int unsigned FIF_B_DE  = 5;
   localparam int unsigned FIF_B_CEL = 6;
   localparam int unsigned FIF_B_CEH = 7;
   localparam int unsigned FIF_B_CI  = 8;
   localparam int unsigned FIF_B_ER  = 9;
   localparam int unsigned FIF_B_PN  = 10;
   localparam int unsigned FIF_B_AV  = 11;

   localparam logic [FIF_REG_W-1:0] FIF_REG_ZERO = 64'h0000_0000_0000_0000;
   localparam logic [FIF_ADDR_W-1:0] FIF_ADDR_RST = 64'h0000_0000_0000_0000;

   // corrected-error generation field codes
   localparam logic [1:0] FIF_GEN_NONE    = 2'h0;
   localparam logic [1:0] FIF_GEN_NONSPEC = 2'h1;
   localparam logic [1:0] FIF_GEN_RSVD    = 2'h2;
   localparam logic [1:0] FIF_GEN_TRPER   = 2'h3;

   // corrected-error codes as recorded in status
   typedef enum logic [1:0] {
      FIF_CE_NONE      = 2'b00,
      FIF_CE_TRANSIENT = 2'b01,
      FIF_CE_NONSPEC   = 2'b10,
      FIF_CE_PERSIST   = 2'b11
   } fif_ce_e;

   // one recorded injected error
   typedef struct packed {
      logic                  valid;
      logic [FIF_ADDR_W-1:0] accAddr;
      logic                  normPn;
      logic                  normEr;
      logic                  normCi;
      fif_ce_e               ceCode;
   } fif_inj_s;

   // injection control register fields
   typedef struct packed {
      logic addrValid;
      logic poisonFlag;
      logic abortSignaledFlag;
      logic critFlag;
      logic overflowFlag;
   } fif_ctl_s;

   // software clear strobes on status
   typedef struct packed {
      logic addrValid;
      logic valid;
      logic overflowFlag;
   } fif_clr_s;

   typedef struct packed {
      logic    addrValid;
      logic    valid;
      logic    poisonFlag;
      logic    abortSignaledFlag;
      logic    critFlag;
      logic    overflowFlag;
      fif_ce_e ce;
   } fif_status_s;

endpackage

// file: tb.sv
// testbench: random and corner tests of the fault injection capability register
`timescale 1ns/10ps
module tb;
   import fif_pkg::*;
   localparam int unsigned IDX    = 2;
   localparam logic [1:0]  CE_CAP = 2'h1;
   localparam logic [15:0] HIT    = 16'h0880;
   logic                  clk;
   logic                  rstn;
   logic                  mmSel;
   logic                  mmWe;
   logic [FIF_MM_AW-1:0]  mmAddr;
   logic [FIF_REG_W-1:0]  mmWdata;
   logic [FIF_REG_W-1:0]  mmRdata;
   logic                  mmRvalid;
   logic                  sysRd;
   logic [FIF_SEL_W-1:0]  sysSel;
   logic [FIF_REG_W-1:0]  sysRdata;
   logic                  sysRvalid;
   fif_inj_s              inj;
   fif_ctl_s              ctl;
   fif_clr_s              clr;
   logic                  addrWr;
   logic [FIF_ADDR_W-1:0] addrWdata;
   fif_status_s           status;
   logic [FIF_ADDR_W-1:0] errAddr;
   logic                  ctlAvReadsOne;
   logic                  addrWritable;
   logic [5:0]            extSupport;
   int                    mismatches;
   int                    checks_done;
   int                    cycles;
   logic                  avM;
   logic [FIF_ADDR_W-1:0] addrM;

   fif_feature_reg #(.REC_INDEX(IDX), .CAP_ER(1'b0), .SUP_CI(1'b0), .CAP_CE(CE_CAP))
   u_fif_feature_reg (
      .clk(clk), .rstn(rstn), .mmSel(mmSel), .mmWe(mmWe), .mmAddr(mmAddr),
      .mmWdata(mmWdata), .mmRdata(mmRdata), .mmRvalid(mmRvalid), .sysRd(sysRd),
      .sysSel(sysSel), .sysRdata(sysRdata), .sysRvalid(sysRvalid), .inj(inj),
      .ctl(ctl), .clr(clr), .addrWr(addrWr), .addrWdata(addrWdata), .status(status),
      .errAddr(errAddr), .ctlAvReadsOne(ctlAvReadsOne), .addrWritable(addrWritable),
      .extSupport(extSupport)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [63:0] capExp();
      logic [63:0] v;
      v = FIF_REG_ZERO;
      v[FIF_B_AV] = 1'b1;
      v[FIF_B_PN] = 1'b1;
      v[FIF_B_CEH:FIF_B_CEL] = CE_CAP;
      v[FIF_B_DE:FIF_B_OF] = 6'h3f;
      return v;
   endfunction

   // reserved field code and codes the field does not allow record as none
   function automatic logic [1:0] ceExp(input logic [1:0] c);
      if (CE_CAP == 2'h1 && c == 2'b10) return c;
      if (CE_CAP == 2'h3 && c[0]) return c;
      return 2'b00;
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // one access per falling edge; strobe is left high for back-to-back use
   task automatic mmAcc(input logic we, input logic [15:0] a);
      logic [63:0] e;
      e = (!we && a == HIT) ? capExp() : FIF_REG_ZERO;
      mmSel = 1'b1;
      mmWe = we;
      mmAddr = a;
      mmWdata = {$urandom, $urandom};
      @(negedge clk);
      chk(mmRvalid, !we, "mm valid");
      chk(mmRdata, e, "mm data");
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles > 5000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      cycles = 0;
      mismatches = 0;
      checks_done = 0;
      rstn = 1'b0;
      mmSel = 1'b0;
      mmWe = 1'b0;
      mmAddr = 16'h0000;
      mmWdata = FIF_REG_ZERO;
      sysRd = 1'b0;
      sysSel = 16'h0000;
      inj = '0;
      ctl = '0;
      clr = '0;
      addrWr = 1'b0;
      addrWdata = FIF_ADDR_RST;
      avM = 1'b0;
      addrM = FIF_ADDR_RST;
      void'($urandom(52));
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      chk(status, '0, "status after reset");
      chk(errAddr, FIF_ADDR_RST, "address after reset");
      chk(ctlAvReadsOne, 1'b0, "control addr flag forced");
      chk(addrWritable, 1'b1, "address writable");
      chk(extSupport, 6'h3f, "extended support");
      $display("test reset done");
      // hit, write to hit, other record, random places, all back to back
      for (int i = 0; i < 16; i++)
         mmAcc(i == 1 || i == 5, (i < 2 || i == 5 || i == 6) ? HIT : (i == 2) ? 16'h0800
               : 16'(FIF_MM_BASE + FIF_MM_STRIDE * ($urandom % 8) + 16'($urandom % 2) * 8));
      mmSel = 1'b0;
      @(negedge clk);
      chk(mmRvalid, 1'b0, "mm idle valid");
      chk(mmRdata, FIF_REG_ZERO, "mm idle data");
      $display("test memory map done");
      for (int i = 0; i < 8; i++) begin
         sysRd = 1'b1;
         sysSel = (i < 2) ? 16'(IDX) : 16'($urandom % 6);
         @(negedge clk);
         chk(sysRvalid, 1'b1, "sys valid");
         chk(sysRdata, (sysSel == IDX) ? capExp() : FIF_REG_ZERO, "sys data");
         chk(sysRdata[FIF_B_AV+1], 1'b0, "misc syndrome capability");
      end
      sysRd = 1'b0;
      $display("test selector done");
      for (int i = 0; i < 24; i++) begin
         addrWr = 1'b1;
         addrWdata = {$urandom, $urandom};
         if (!avM) addrM = addrWdata;
         @(negedge clk);
         addrWr = 1'b0;
         chk(errAddr, addrM, "address write");
         inj = {1'b1, $urandom, $urandom, 3'($urandom), 2'($urandom)};
         ctl = 5'($urandom);
         clr = 3'($urandom);
         @(negedge clk);
         inj.valid = 1'b0;
         clr = '0;
         chk(status.valid, 1'b1, "record valid");
         chk(status.addrValid, ctl.addrValid, "record addr flag");
         chk(errAddr, addrM, "address kept");
         chk(status.poisonFlag, ctl.poisonFlag, "poison");
         chk(status.abortSignaledFlag, inj.normEr, "abort");
         chk(status.critFlag, inj.normCi, "critical");
         chk(status.overflowFlag, ctl.overflowFlag, "overflow");
         chk(status.ce, ceExp(inj.ceCode), "corrected code");
         avM = ctl.addrValid;
         if ($urandom % 2) begin
            clr.addrValid = 1'b1;
            avM = 1'b0;
            @(negedge clk);
            clr = '0;
         end
         chk(addrWritable, !avM, "writable");
      end
      clr.valid = 1'b1;
      @(negedge clk);
      clr = '0;
      chk(status.valid, 1'b0, "valid cleared");
      chk(status.poisonFlag, 1'b0, "poison cleared");
      chk(status.abortSignaledFlag, 1'b0, "abort cleared");
      chk(status.critFlag, 1'b0, "critical cleared");
      chk(status.ce, 2'b00, "corrected code cleared");
      $display("test record done");
      // reset in mid-run, then a read right after release
      rstn = 1'b0;
      @(negedge clk);
      chk(status, '0, "status in reset");
      chk(errAddr, FIF_ADDR_RST, "address in reset");
      rstn = 1'b1;
      mmAcc(1'b0, HIT);
      mmSel = 1'b0;
      @(negedge clk);
      chk(mmRvalid, 1'b0, "mm valid after reset read");
      $display("test mid reset done");
      wrap_up();
   end
endmodule // tb
